// *** src/srdsm_pkg.sv ***
package srdsm_pkg;

  // Register bus geometry and byte addresses
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG0_ADDR   = 4'h0;
  localparam logic [3:0]  REG1_ADDR   = 4'h4;
  localparam logic [3:0]  STAT_ADDR   = 4'h8;

  // Register 0 fields
  localparam int          FRAC_LSB    = 4;
  localparam int          FRAC_W      = 15;
  localparam int          INT_LSB     = 19;
  localparam int          INT_W       = 8;
  localparam int          MUX_LSB     = 29;
  localparam int          MUX_W       = 3;

  // Register 1 fields
  localparam int          RDIV_LSB    = 4;
  localparam int          RDIV_W      = 3;
  localparam int          CKDIV_LSB   = 7;
  localparam int          CKDIV_W     = 4;
  localparam int          OSCEN_BIT   = 12;
  localparam int          BIAS_LSB    = 13;
  localparam int          BIAS_W      = 2;
  localparam int          HALVE_BIT   = 18;

  // Power-up values and writable bits
  localparam logic [31:0] REG0_RESET  = 32'h0000_0000;
  localparam logic [31:0] REG1_RESET  = 32'h0000_1210;
  localparam logic [31:0] REG0_WMASK  = 32'he7ff_fff0;
  localparam logic [31:0] REG1_WMASK  = 32'h0004_7ff0;

  // Status register bit positions
  localparam int          ST_SUPPLY   = 0;
  localparam int          ST_CAL      = 1;
  localparam int          ST_LOCK     = 2;
  localparam int          ST_RSSI     = 3;
  localparam int          ST_TXRX     = 4;

  // Status output source codes
  typedef enum logic [2:0] {
    SRDSM_MUX_SUPPLY = 3'h0,
    SRDSM_MUX_CAL    = 3'h1,
    SRDSM_MUX_LOCK   = 3'h2,
    SRDSM_MUX_RSSI   = 3'h3,
    SRDSM_MUX_TXRX   = 3'h4
  } srdsm_mux_t;

  // Timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          SUPPLY_UP_US  = 50;
  localparam int          SUPPLY_UP_CYC = SUPPLY_UP_US * 1000 / CLK_PERIOD_NS;
  localparam int          LOCK_SET_NS   = 15;
  localparam int          LOCK_SET_CYC  = (LOCK_SET_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          LOCK_SET_NS / CLK_PERIOD_NS;
  localparam int          LOCK_CLR_NS   = 25;
  localparam int          LOCK_CLR_CYC  = (LOCK_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LOCK_RUNS     = 5;

endpackage : srdsm_pkg

// *** src/srdsm_top.sv ***
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Oscillator on when bit set, and powered
// - Two-bit oscillator bias field drives bias
// - Divided reference output 50:50, inverted phase
// - Divided output even ratios 2..30
// - Divided output defaults to divide-by-eight
// - Divide field zero stops divided output
// - Reference divider 1..7 clocks phase detector
// - Reference divider defaults to one
// - Feedback divider integer plus fractional parts
// - Output frequency formula, optional halving select
// - Power enable low clears all registers
// - Supply-good rises 50 us after enable
// - Status select field, defaults to supply-good
// - Calibration flag low during coarse/fine calibration
// - Lock after five errors under 15 ns
// - Lock clears on 25 ns error
// - Signal-level-valid follows settled measurement
// - Direction low transmitting, high receiving
module srdsm_top (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      chip_enable,
  input  wire logic                      cal_coarse_busy,
  input  wire logic                      cal_fine_busy,
  input  wire logic                      level_settled,
  input  wire logic                      tx_mode,
  input  wire logic                      vco_div_in,
  input  wire logic [srdsm_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [31:0]               bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output logic      [31:0]               bus_rdata,
  output logic                           regulator_enable,
  output logic                           osc_enable,
  output logic      [1:0]                osc_bias_field,
  output logic                           divided_ref_output,
  output logic                           pfd_ref_tick,
  output logic                           fb_tick,
  output logic                           output_halving_select,
  output logic                           pll_lock,
  output logic                           status_output
);
  import srdsm_pkg::*;

  localparam int PIN_W = 6;  // ce, coarse, fine, settled, tx, vco
  localparam int P_CE  = 0;
  localparam int P_CC  = 1;
  localparam int P_CF  = 2;
  localparam int P_LV  = 3;
  localparam int P_TX  = 4;
  localparam int P_VCO = 5;

  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic             vco_prev;
    logic [31:0]      reg0;
    logic [31:0]      reg1;
    logic [31:0]      rdata;
    logic [11:0]      supply_cnt;
    logic             supply_good;
    logic [3:0]       ck_cnt;
    logic             ck_out;
    logic [2:0]       r_cnt;
    logic             ref_tick;
    logic [8:0]       fb_cnt;
    logic [8:0]       fb_mod;
    logic [14:0]      frac_acc;
    logic             fb_pulse;
    logic             ph_active;
    logic             ph_from_ref;
    logic [7:0]       ph_cnt;
    logic [2:0]       good_runs;
    logic             lock;
    logic             stat_out;
    logic             osc_en;
    logic [1:0]       bias;
    logic             halve;
    logic             reg_en;
  } srdsm_state_t;

  localparam srdsm_state_t ST_RESET = '{
    pin_s1: '0, pin_s2: '0, vco_prev: 1'b0,
    reg0: REG0_RESET, reg1: REG1_RESET, rdata: 32'h0000_0000,
    supply_cnt: 12'h000, supply_good: 1'b0,
    ck_cnt: 4'h0, ck_out: 1'b0, r_cnt: 3'h0, ref_tick: 1'b0,
    fb_cnt: 9'h000, fb_mod: 9'h000, frac_acc: 15'h0000, fb_pulse: 1'b0,
    ph_active: 1'b0, ph_from_ref: 1'b0, ph_cnt: 8'h00,
    good_runs: 3'h0, lock: 1'b0, stat_out: 1'b0,
    osc_en: 1'b0, bias: 2'h0, halve: 1'b0, reg_en: 1'b0
  };

  // Address decode shared by reads and writes
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [3:0]        target);
    addr_hit = (a == target);
  endfunction : addr_hit

  // Status source selection; unused codes read low
  function automatic logic mux_pick(input logic [MUX_W-1:0] sel,
                                    input logic [4:0]       flags);
    case (sel)
      SRDSM_MUX_SUPPLY: mux_pick = flags[ST_SUPPLY];
      SRDSM_MUX_CAL:    mux_pick = flags[ST_CAL];
      SRDSM_MUX_LOCK:   mux_pick = flags[ST_LOCK];
      SRDSM_MUX_RSSI:   mux_pick = flags[ST_RSSI];
      SRDSM_MUX_TXRX:   mux_pick = flags[ST_TXRX];
      default:          mux_pick = 1'b0;
    endcase
  endfunction : mux_pick

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  srdsm_state_t st;
  srdsm_state_t next_st;

  logic             ce;
  logic [4:0]       flags;
  logic             vco_edge;
  logic [3:0]       ck_half;
  logic [2:0]       r_div;
  logic [7:0]       int_n;
  logic [14:0]      frac_n;
  logic [15:0]      acc_sum;
  logic [7:0]       err;
  logic             meas_done;

  always_comb begin
    next_st   = st;
    ce        = st.pin_s2[P_CE];
    ck_half   = st.reg1[CKDIV_LSB +: CKDIV_W];
    r_div     = st.reg1[RDIV_LSB +: RDIV_W];
    int_n     = st.reg0[INT_LSB +: INT_W];
    frac_n    = st.reg0[FRAC_LSB +: FRAC_W];
    vco_edge  = st.pin_s2[P_VCO] & ~st.vco_prev;
    acc_sum   = {1'b0, st.frac_acc} + {1'b0, frac_n};
    err       = 8'h00;
    meas_done = 1'b0;

    // Pins pass two flops; only the second stage is read
    next_st.pin_s1   = {vco_div_in, tx_mode, level_settled,
                        cal_fine_busy, cal_coarse_busy, chip_enable};
    next_st.pin_s2   = st.pin_s1;
    next_st.vco_prev = st.pin_s2[P_VCO];

    // Flags in status register bit order
    flags[ST_SUPPLY] = st.supply_good;
    flags[ST_CAL]    = ~(st.pin_s2[P_CC] | st.pin_s2[P_CF]);
    flags[ST_LOCK]   = st.lock;
    flags[ST_RSSI]   = st.pin_s2[P_LV];
    flags[ST_TXRX]   = ~st.pin_s2[P_TX];

    // Regulator follows power enable; ready after settle time
    next_st.reg_en = ce;
    if (st.supply_cnt >= 12'(SUPPLY_UP_CYC - 1)) begin
      next_st.supply_good = 1'b1;
    end else begin
      next_st.supply_cnt = st.supply_cnt + 12'h001;
    end

    // Register writes; only defined bits, plus unassigned reg1 bit 11, are stored
    if (bus_wr && addr_hit(bus_addr, REG0_ADDR)) begin
      next_st.reg0 = bus_wdata & REG0_WMASK;
    end
    if (bus_wr && addr_hit(bus_addr, REG1_ADDR)) begin
      next_st.reg1 = bus_wdata & REG1_WMASK;
    end

    // Read data stands in the cycle after the strobe only
    next_st.rdata = 32'h0000_0000;
    if (bus_rd) begin
      if (addr_hit(bus_addr, REG0_ADDR)) begin
        next_st.rdata = st.reg0;
      end else if (addr_hit(bus_addr, REG1_ADDR)) begin
        next_st.rdata = st.reg1;
      end else if (addr_hit(bus_addr, STAT_ADDR)) begin
        next_st.rdata = {27'h0, flags};
      end
    end

    // Oscillator control gated by power enable
    next_st.osc_en = st.reg1[OSCEN_BIT] & ce;
    next_st.bias   = st.reg1[BIAS_LSB +: BIAS_W];
    next_st.halve  = st.reg1[HALVE_BIT];

    // Divided reference: half period of field cycles, so ratio is twice
    // the field and duty is exactly even; starts low and rises after the
    // first half period, counted apart from the reference divider
    if (ck_half == 4'h0) begin
      next_st.ck_cnt = 4'h0;
      next_st.ck_out = 1'b0;
    end else if (st.ck_cnt >= ck_half - 4'h1) begin
      next_st.ck_cnt = 4'h0;
      next_st.ck_out = ~st.ck_out;
    end else begin
      next_st.ck_cnt = st.ck_cnt + 4'h1;
    end

    // Reference divider pulse, one cycle every R cycles; zero acts as one
    next_st.ref_tick = 1'b0;
    if (r_div <= 3'h1 || st.r_cnt >= r_div - 3'h1) begin
      next_st.r_cnt    = 3'h0;
      next_st.ref_tick = 1'b1;
    end else begin
      next_st.r_cnt = st.r_cnt + 3'h1;
    end

    // Feedback divider: modulus is integer plus sigma-delta carry.
    // Integer values below 23 are outside the supported range.
    next_st.fb_pulse = 1'b0;
    if (vco_edge) begin
      if (st.fb_cnt + 9'h001 >= st.fb_mod) begin
        next_st.fb_cnt   = 9'h000;
        next_st.fb_pulse = 1'b1;
        next_st.frac_acc = acc_sum[14:0];
        next_st.fb_mod   = {1'b0, int_n} + {8'h00, acc_sum[15]};
      end else begin
        next_st.fb_cnt = st.fb_cnt + 9'h001;
      end
    end

    // Phase error: cycles from the first edge to the other one
    if (!st.ph_active) begin
      if (st.ref_tick && st.fb_pulse) begin
        meas_done = 1'b1;  // Coincident edges, zero error
      end else if (st.ref_tick || st.fb_pulse) begin
        next_st.ph_active   = 1'b1;
        next_st.ph_from_ref = st.ref_tick;
        next_st.ph_cnt      = 8'h01;
      end
    end else begin
      if ((st.ph_from_ref && st.fb_pulse) || (!st.ph_from_ref && st.ref_tick)) begin
        meas_done         = 1'b1;
        err               = st.ph_cnt;
        next_st.ph_active = 1'b0;
      end else if ((st.ph_from_ref && st.ref_tick) ||
                   (!st.ph_from_ref && st.fb_pulse)) begin
        meas_done         = 1'b1;  // Same edge twice: far off
        err               = 8'hff;
        next_st.ph_active = 1'b0;
      end else if (st.ph_cnt != 8'hff) begin
        next_st.ph_cnt = st.ph_cnt + 8'h01;
      end
    end

    // Lock qualification and loss
    if (meas_done) begin
      if (err < 8'(LOCK_SET_CYC)) begin
        if (st.good_runs >= 3'(LOCK_RUNS - 1)) begin
          next_st.lock = 1'b1;
        end else begin
          next_st.good_runs = st.good_runs + 3'h1;
        end
      end else begin
        next_st.good_runs = 3'h0;
      end
      if (err >= 8'(LOCK_CLR_CYC)) begin
        next_st.lock = 1'b0;
      end
    end

    // Status output source
    next_st.stat_out = mux_pick(st.reg0[MUX_LSB +: MUX_W], flags);

    // Power enable low wipes every stored value except the pin synchroniser back to defaults
    if (!ce) begin
      next_st        = ST_RESET;
      next_st.pin_s1 = {vco_div_in, tx_mode, level_settled,
                        cal_fine_busy, cal_coarse_busy, chip_enable};
      next_st.pin_s2 = st.pin_s1;
    end
  end

  // Whole state in one register bank
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign bus_rdata             = st.rdata;
  assign regulator_enable      = st.reg_en;
  assign osc_enable            = st.osc_en;
  assign osc_bias_field        = st.bias;
  assign divided_ref_output    = st.ck_out;
  assign pfd_ref_tick          = st.ref_tick;
  assign fb_tick               = st.fb_pulse;
  assign output_halving_select = st.halve;
  assign pll_lock              = st.lock;
  assign status_output         = st.stat_out;

endmodule : srdsm_top

// *** testbench/srdsm_sva.sv ***
`timescale 1ns/1ps
module srdsm_sva (
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire logic                         chip_enable,
  input wire logic [srdsm_pkg::ADDR_W-1:0] bus_addr,
  input wire logic                         bus_wr,
  input wire logic                         regulator_enable,
  input wire logic                         osc_enable,
  input wire logic [1:0]                   osc_bias_field,
  input wire logic                         output_halving_select,
  input wire logic                         pfd_ref_tick,
  input wire logic                         fb_tick,
  input wire logic                         pll_lock
);
  import srdsm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Pin low long enough to cross the two-flop synchroniser
  sequence ce_low_run;
    !chip_enable [*4];
  endsequence
  // Longer run, since release of reset adds its own synchroniser
  sequence ce_high_run;
    chip_enable [*8];
  endsequence
  // Window wide enough to allow for the write-to-output latency
  sequence no_reg1_wr;
    !(bus_wr && bus_addr == REG1_ADDR) [*3];
  endsequence

  osc_off_a: assert property (ce_low_run |-> !osc_enable)
    else $error("oscillator on while powered down");
  reg_off_a: assert property (ce_low_run |-> !regulator_enable)
    else $error("regulator on while powered down");
  reg_on_a: assert property (ce_high_run |-> regulator_enable)
    else $error("regulator off while powered");
  lock_off_a: assert property (ce_low_run |-> !pll_lock)
    else $error("lock flag kept through power down");
  pfd_gap_a: assert property (disable iff (!rst_n || !chip_enable)
    pfd_ref_tick |=> ##[0:6] pfd_ref_tick)
    else $error("reference tick gap above seven");
  lock_cause_a: assert property ($rose(pll_lock) |->
    ($past(fb_tick) && $past(pfd_ref_tick)) || ($past(fb_tick, 2) && $past(pfd_ref_tick, 2)))
    else $error("lock rose without aligned ticks");
  bias_hold_a: assert property (disable iff (!rst_n || !chip_enable)
    no_reg1_wr |=> $stable(osc_bias_field))
    else $error("bias changed without a write");
  halve_hold_a: assert property (disable iff (!rst_n || !chip_enable)
    no_reg1_wr |=> $stable(output_halving_select))
    else $error("halving changed without a write");
endmodule : srdsm_sva

bind srdsm_top srdsm_sva u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .chip_enable(chip_enable), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .regulator_enable(regulator_enable), .osc_enable(osc_enable),
  .osc_bias_field(osc_bias_field), .output_halving_select(output_halving_select),
  .pfd_ref_tick(pfd_ref_tick), .fb_tick(fb_tick), .pll_lock(pll_lock)
);

// *** testbench/srdsm_host.sv ***
`timescale 1ns/1ps
module srdsm_host (
  input  wire logic                         core_clk,
  input  wire logic [31:0]                  bus_rdata,
  input  wire logic                         status_output,
  output logic      [srdsm_pkg::ADDR_W-1:0] bus_addr,
  output logic      [31:0]                  bus_wdata,
  output logic                              bus_wr,
  output logic                              bus_rd
);
  import srdsm_pkg::*;

  // Idle bus from time zero, so no stray strobe meets reset release
  initial begin
    bus_addr  = '0;
    bus_wdata = '0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge core_clk);
    bus_rd   <= 1'b0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask : rd

  // Interface is unpowered until supply-good, so no access before it
  task automatic wait_supply(output int n);
    n = 0;
    while (status_output !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_supply
endmodule : srdsm_host

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  import srdsm_pkg::*;
  logic              core_clk, rst_n, chip_enable, cal_coarse_busy, cal_fine_busy;
  logic              level_settled, tx_mode, vco_div_in, vco_hold, bus_wr, bus_rd;
  logic [ADDR_W-1:0] bus_addr;
  logic [31:0]       bus_wdata, bus_rdata, d;
  logic              regulator_enable, osc_enable, divided_ref_output, pfd_ref_tick;
  logic              fb_tick, output_halving_select, pll_lock, status_output;
  logic [1:0]        osc_bias_field;
  int                n_fail, n_compared, n;

  srdsm_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .chip_enable(chip_enable),
    .cal_coarse_busy(cal_coarse_busy), .cal_fine_busy(cal_fine_busy),
    .level_settled(level_settled), .tx_mode(tx_mode), .vco_div_in(vco_div_in),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .regulator_enable(regulator_enable), .osc_enable(osc_enable),
    .osc_bias_field(osc_bias_field), .divided_ref_output(divided_ref_output),
    .pfd_ref_tick(pfd_ref_tick), .fb_tick(fb_tick),
    .output_halving_select(output_halving_select), .pll_lock(pll_lock),
    .status_output(status_output)
  );
  srdsm_host host (
    .core_clk(core_clk), .bus_rdata(bus_rdata), .status_output(status_output),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Prescaled oscillator stand-in, one rising edge every two cycles;
  // a hold skips one toggle so the feedback slips one cycle in phase
  always @(posedge core_clk) begin
    if (!vco_hold) vco_div_in <= ~vco_div_in;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Defaults, the reg0 write mask and an unmapped address
  task automatic t_bus();
    host.rd(REG1_ADDR, d);
    `CHK("reg1 default", 32'h1210, d)
    host.rd(REG0_ADDR, d);
    `CHK("reg0 default", 32'h0, d)
    host.wr(REG0_ADDR, '1);
    host.rd(REG0_ADDR, d);
    `CHK("reg0 fields", 32'he7ff_fff0, d)
    host.wr(4'hc, '1);
    host.rd(4'hc, d);
    `CHK("unmapped", 32'h0, d)
    host.wr(REG0_ADDR, 32'h0);
  endtask : t_bus

  // Half periods of the divided output; field zero stops it
  task automatic t_ckout(input int f);
    int hi, lo, k;
    hi = 0;
    lo = 0;
    host.wr(REG1_ADDR, 32'h1010 | (32'(f) << CKDIV_LSB));
    cyc(4);
    for (k = 0; k < 64 && divided_ref_output !== 1'b0; k++) cyc(1);
    for (k = 0; k < 64 && divided_ref_output !== 1'b1; k++) cyc(1);
    while (divided_ref_output === 1'b1 && hi < 64) begin
      cyc(1);
      hi++;
    end
    while (divided_ref_output === 1'b0 && lo < 64) begin
      cyc(1);
      lo++;
    end
    `CHK("ckout high", f, hi)
    `CHK("ckout low", (f == 0) ? 64 : f, lo)
  endtask : t_ckout

  // Bias, oscillator enable and halving follow their fields
  task automatic t_reg1();
    for (int b = 0; b < 4; b++) begin
      host.wr(REG1_ADDR, 32'h0210 | (32'(b) << BIAS_LSB) | (32'(b % 2) << OSCEN_BIT)
                         | (32'(b / 2) << HALVE_BIT));
      cyc(4);
      `CHK("bias", 2'(b), osc_bias_field)
      `CHK("osc enable", 1'(b % 2), osc_enable)
      `CHK("halving", 1'(b / 2), output_halving_select)
    end
  endtask : t_reg1

  // Two feedback periods span twice the integer plus the fraction in edges, checked in cycles at two per edge
  task automatic t_fb(input int nint, input int frac);
    int g, k;
    host.wr(REG0_ADDR, (32'(nint) << INT_LSB) | (32'(frac) << FRAC_LSB));
    cyc(200);
    for (k = 0; k < 600 && fb_tick !== 1'b1; k++) cyc(1);
    g = 0;
    for (k = 0; k < 2; k++) begin
      do begin
        cyc(1);
        g++;
      end while (fb_tick !== 1'b1 && g < 600);
    end
    `CHK("fb span", 2 * (2 * nint + ((2 * frac) >> 15)), g)
    `CHK("no lock", 1'b0, pll_lock)
  endtask : t_fb

  // Status source select against driven flag inputs
  task automatic t_mux(input int sel, input logic cc, cf, lv, tx, ex);
    host.wr(REG0_ADDR, (32'(sel) << MUX_LSB) | (32'h17 << INT_LSB));
    cal_coarse_busy <= cc;
    cal_fine_busy   <= cf;
    level_settled   <= lv;
    tx_mode         <= tx;
    cyc(8);
    `CHK("status out", ex, status_output)
  endtask : t_mux

  // Reference tick spacing equals the R field
  task automatic t_rdiv(input int r);
    int g, k;
    host.wr(REG1_ADDR, 32'h1200 | (32'(r) << RDIV_LSB));
    cyc(10);
    for (k = 0; k < 16 && pfd_ref_tick !== 1'b1; k++) cyc(1);
    g = 0;
    do begin
      cyc(1);
      g++;
    end while (pfd_ref_tick !== 1'b1 && g < 16);
    `CHK("pfd gap", r, g)
  endtask : t_rdiv

  // Feedback at the reference rate, slipped until edges coincide; the
  // integer part sits below the legal floor only to reach that rate
  task automatic t_lock();
    int k, w;
    host.wr(REG1_ADDR, 32'h1000 | (32'h6 << RDIV_LSB));
    host.wr(REG0_ADDR, (32'h2 << MUX_LSB) | (32'h3 << INT_LSB));
    for (k = 0; k < 12 && pll_lock !== 1'b1; k++) begin
      for (w = 0; w < 48 && pll_lock !== 1'b1; w++) cyc(1);
      vco_hold <= 1'b1;
      cyc(1);
      vco_hold <= 1'b0;
    end
    cyc(2);
    `CHK("lock set", 1'b1, pll_lock)
    `CHK("lock on status", 1'b1, status_output)
    host.wr(REG1_ADDR, 32'h1000 | (32'h5 << RDIV_LSB));
    for (k = 0; k < 64 && pll_lock !== 1'b0; k++) cyc(1);
    `CHK("lock cleared", 1'b0, pll_lock)
    host.wr(REG0_ADDR, 32'h17 << INT_LSB);
  endtask : t_lock

  // Power down clears registers; supply-good timing on return
  task automatic t_power();
    host.wr(REG1_ADDR, 32'h1000);
    cyc(4);
    `CHK("osc on", 1'b1, osc_enable)
    chip_enable <= 1'b0;
    cyc(10);
    `CHK("regulator off", 1'b0, regulator_enable)
    `CHK("osc off", 1'b0, osc_enable)
    chip_enable <= 1'b1;
    host.wait_supply(n);
    `CHK("supply time", 1'b1, n >= SUPPLY_UP_CYC && n <= SUPPLY_UP_CYC + 10)
    host.rd(REG1_ADDR, d);
    `CHK("reg1 cleared", 32'h1210, d)
  endtask : t_power

  initial begin
    {rst_n, cal_coarse_busy, cal_fine_busy, level_settled, tx_mode, vco_div_in, vco_hold} = '0;
    chip_enable = 1'b1;
    n_fail      = 0;
    n_compared  = 0;
    cyc(10);
    rst_n <= 1'b1;
    host.wait_supply(n);
    `CHK("supply up", 1'b1, n < 4000)
    if (n >= 4000) finish_test();
    t_bus();
    t_ckout(0);
    t_ckout(1);
    t_ckout(4);
    t_ckout(15);
    t_reg1();
    t_fb(23, 0);
    t_fb(40, 0);
    t_fb(30, 15'h4000);
    t_mux(0, 1, 1, 0, 1, 1'b1);
    t_mux(1, 1, 0, 1, 0, 1'b0);
    t_mux(1, 0, 1, 1, 0, 1'b0);
    t_mux(1, 0, 0, 0, 1, 1'b1);
    t_mux(2, 0, 0, 1, 0, 1'b0);
    t_mux(3, 1, 1, 0, 0, 1'b0);
    t_mux(3, 0, 0, 1, 1, 1'b1);
    t_mux(4, 0, 0, 0, 1, 1'b0);
    t_mux(4, 1, 1, 1, 0, 1'b1);
    for (int s = 5; s < 8; s++) t_mux(s, 0, 0, 1, 0, 1'b0);
    t_lock();
    for (int r = 1; r < 8; r++) t_rdiv(r);
    t_power();
    finish_test();
  end
endmodule : tb_top
